// [src/mpo_pkg.sv]
// Shared constants, field layout and types of the motion parameter loader
package mpo_pkg;
	// ****************************************************
	// Register map of the plain register port
	// ****************************************************
	localparam logic [3:0] REG_MOTOR_A  = 4'h0;  // run / hold current codes
	localparam logic [3:0] REG_MOTOR_B  = 4'h1;  // ramp, direction, resolution
	localparam logic [3:0] REG_STALL_UV = 4'h2;  // stall threshold, undervoltage select
	localparam logic [3:0] REG_SAFE_HI  = 4'h3;  // safe position bits 10:8
	localparam logic [3:0] REG_SAFE_LO  = 4'h4;  // safe position bits 7:0
	localparam logic [3:0] REG_CFG      = 4'h5;  // bank select, failsafe, sleep allow (read)
	localparam logic [3:0] REG_NODE     = 4'h6;  // node address (read)
	localparam logic [3:0] REG_STATUS   = 4'h7;  // loader state (read)
	localparam logic [3:0] REG_OTP_ADDR = 4'h8;  // write starts a one-time memory byte read
	localparam logic [3:0] REG_OTP_DATA = 4'h9;  // result of that read
	// ****************************************************
	// One-time memory byte addresses and field positions
	// ****************************************************
	localparam logic [3:0] OTP_BANK_BYTE = 4'h1;  // bank select in bit 7
	localparam logic [3:0] OTP_ADDR_BYTE = 4'h2;  // stall threshold 7:4, address bits 3:0
	localparam logic [3:0] OTP_CURR_BYTE = 4'h3;  // run 7:4, hold 3:0
	localparam logic [3:0] OTP_POS_HI    = 4'h5;  // safe 10:8, direction, ramp
	localparam logic [3:0] OTP_POS_LO    = 4'h6;  // safe 7:2, failsafe, sleep allow
	localparam logic [3:0] OTP_MODE_BYTE = 4'h7;  // undervoltage 6:4, resolution 3:2
	localparam logic [3:0] OTP_ALT_HI    = 4'h8;
	localparam logic [3:0] OTP_ALT_LO    = 4'h9;
	localparam logic [3:0] OTP_LAST      = 4'h9;
	localparam int         POS_DIR_BIT   = 4;
	localparam int         LO_FS_BIT     = 1;
	localparam int         LO_SLEEP_BIT  = 0;
	localparam int         BANK_BIT      = 7;
	localparam logic [8:0] SAFE_RESERVED = 9'h100;  // stored bits 10:2 that disable auto safe move
	localparam logic       NODE_TOP_BIT  = 1'b0;    // top bit of the node address
	localparam logic [3:0] HOLD_ZERO     = 4'hF;    // hold code meaning no current
	// ****************************************************
	// Timing
	// ****************************************************
	localparam int CLK_PERIOD_NS = 25;
	localparam int HOLD_LOW_NS   = 1000;  // time at lowest level before the bridge is parked
	localparam int HOLD_LOW_CYC  = (HOLD_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// ****************************************************
	// Types
	// ****************************************************
	typedef struct packed {
		logic [3:0]  run_code;
		logic [3:0]  hold_code;
		logic [3:0]  ramp_code;
		logic        dir_ccw;
		logic [1:0]  microstep_resolution;
		logic [3:0]  stall_bemf_threshold;
		logic [2:0]  undervoltage_level_select;
		logic [10:0] safe_target_position;
		logic        failsafe;
		logic        sleep_allow;
		logic        alt_safe_bank_select;
		logic [3:0]  node_addr_low_bits;
	} mpo_params_t;
	typedef enum logic [2:0] {
		ST_LOAD_REQ  = 3'b000,
		ST_LOAD_WAIT = 3'b001,
		ST_RUN       = 3'b010,
		ST_RD_REQ    = 3'b011,
		ST_RD_WAIT   = 3'b100
	} mpo_state_t;
	typedef enum logic [1:0] {
		HS_RUN  = 2'b00,
		HS_HOLD = 2'b01,
		HS_LOW  = 2'b10,
		HS_OFF  = 2'b11
	} mpo_hold_t;
endpackage : mpo_pkg

// [src/mpo_cur_table.sv]
// Coil amplitude lookup in milliamps, registered output
`timescale 1ns/1ps
`default_nettype none
module mpo_cur_table import mpo_pkg::*; (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	// Code in
	input  wire logic [3:0]  code,
	input  wire logic        boost,
	input  wire logic        zero,
	// Amplitude out
	output logic      [10:0] amp_ma
);
	// ****************************************************
	// Tables
	// ****************************************************
	localparam logic [10:0] NORM [16] = '{11'h03B, 11'h047, 11'h054, 11'h064, 11'h077, 11'h08D, 11'h0A8,
		11'h0C8, 11'h0EE, 11'h11B, 11'h150, 11'h190, 11'h1DC, 11'h236, 11'h2A1, 11'h320};
	localparam logic [10:0] BOOST [16] = '{11'h051, 11'h062, 11'h074, 11'h08A, 11'h0A4, 11'h0C2, 11'h0E7,
		11'h113, 11'h147, 11'h185, 11'h1CE, 11'h226, 11'h28F, 11'h30A, 11'h39D, 11'h44C};
	// Registered lookup, zero forces no current
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			amp_ma <= 11'h000;
		else if (zero)
			amp_ma <= 11'h000;
		else
			amp_ma <= boost ? BOOST[code] : NORM[code];  // RULE5
	end
endmodule : mpo_cur_table
`default_nettype wire

// [src/mpo_hold_seq.sv]
// Run to hold current reduction sequencer
`timescale 1ns/1ps
`default_nettype none
module mpo_hold_seq import mpo_pkg::*; (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rstn,
	// Motion and codes
	input  wire logic       moving,
	input  wire logic [3:0] run_code,
	input  wire logic [3:0] hold_code,
	// Bridge control
	output logic      [3:0] coil_code,
	output logic            coil_zero,
	output logic            pwm_enable,
	output logic            bottom_ground
);
	mpo_hold_t  st;
	logic [7:0] cnt;
	initial assert (HOLD_LOW_CYC < 256) else $error("hold low count too wide");
	// Sequence state and dwell counter
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			st  <= HS_HOLD;
			cnt <= 8'h00;
		end else if (moving) begin
			st  <= HS_RUN;
			cnt <= 8'h00;
		end else unique case (st)
			HS_RUN:  st <= (hold_code == HOLD_ZERO) ? HS_LOW : HS_HOLD;  // RULE11 RULE12
			HS_HOLD: begin
				cnt <= 8'h00;  // Fresh dwell count on every zero-hold entry
				st  <= (hold_code == HOLD_ZERO) ? HS_LOW : HS_HOLD;
			end
			HS_LOW: begin
				cnt <= cnt + 8'h01;
				if (cnt == 8'(HOLD_LOW_CYC - 1))
					st <= HS_OFF;  // RULE12
			end
			HS_OFF:  st <= (hold_code == HOLD_ZERO) ? HS_OFF : HS_HOLD;
		endcase
	end
	// Outputs from state
	always_comb begin
		coil_code     = (st == HS_RUN) ? run_code : (st == HS_HOLD) ? hold_code : 4'h0;  // RULE10
		coil_zero     = (st == HS_OFF);
		pwm_enable    = (st != HS_OFF);
		bottom_ground = (st == HS_OFF);
	end
	AST_ZERO_SEQ: assert property (@(posedge clk_sys) disable iff (!rstn)
		(st == HS_LOW) && (cnt == 8'(HOLD_LOW_CYC - 1)) && !moving |=> !pwm_enable && bottom_ground)  // RULE12
		else $error("bridge not parked after low step");
endmodule : mpo_hold_seq
`default_nettype wire

// [src/mpo_loader.sv]
// Motion parameter loader: one-time memory copy, RAM shadow, decode and events
//
// Summary of operation
// RULE1 - Bus writes replace shadow fields except address; bank, failsafe and sleep allow are not writable here
// RULE2 - Node address from four programmed, three pin bits
// RULE3 - Stall code zero disables motion detection
// RULE4 - Undervoltage code picks stop and resume levels
// RULE5 - Run code selects one of sixteen amplitudes
// RULE6 - Direction bit sets rotation sense
// RULE7 - Link loss or error overflow moves safe
// RULE8 - Reserved safe pattern holds; explicit command works
// RULE9 - Safe position eleven bits, low two zero; a bus write to REG_SAFE_LO stores bits 1:0 as written
// RULE10 - Hold code F means zero hold
// RULE11 - Stopping reduces run current to hold current
// RULE12 - Zero hold: lowest level, then bridge parked
// RULE13 - Resolution field gives half to sixteenth stepping
// RULE14 - Bank bit chooses primary or alternate safe bytes
// RULE15 - Bank bit redirects reads of bytes five, six
// RULE16 - Ramp code sets acceleration rate
// RULE17 - Sleep allowed: timeout enters sleep
// RULE18 - Sleep disallowed: timeout stops, except standby, shutdown
// RULE19 - Sleep command sleeps or stops per allow bit
// RULE20 - Copy memory once after reset, use shadow
`timescale 1ns/1ps
`default_nettype none
module mpo_loader import mpo_pkg::*; #(
	parameter int DATA_W = 8
) (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	// Register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	// One-time memory read port, data one cycle after the strobe
	output logic      [3:0]  otp_addr,
	output logic             otp_rd,
	input  wire logic [7:0]  otp_rdata,
	// Link events
	input  wire logic [2:0]  hardwired_addr_pins,
	input  wire logic        link_lost,
	input  wire logic        err_overflow,
	input  wire logic        goto_safe_position_cmd,
	input  wire logic        link_timeout,
	input  wire logic        go_sleep_cmd,
	input  wire logic        standby_or_shutdown,
	// Motion state
	input  wire logic        moving,
	input  wire logic        boost,
	// Decoded parameters
	output logic      [7:0]  node_address,
	output logic             stall_detect_en,
	output logic      [13:0] low_batt_stop_level,
	output logic      [13:0] low_batt_resume_level,
	output logic      [15:0] accel_rate,
	output logic             accel_speed_limited,
	output logic      [4:0]  microstep_div,
	output logic             dir_ccw,
	output logic      [10:0] coil_amp_ma,
	output logic             pwm_enable,
	output logic             bottom_ground,
	// Actions
	output logic             safe_move_start,
	output logic      [15:0] safe_target,
	output logic             hold_in_place,
	output logic             sleep_enter,
	output logic             stop_enter,
	output logic             loaded
);
	initial assert (DATA_W == 8) else $error("register port must be 8 bits wide");
	// ****************************************************
	// Constant tables
	// ****************************************************
	localparam logic [15:0] ACC_TAB [16] = '{16'h0031, 16'h00DA, 16'h03EC, 16'h0E19, 16'h1854, 16'h2290,
		16'h2C91, 16'h3692, 16'h4093, 16'h4A94, 16'h557E, 16'h5F7F, 16'h6980, 16'h7382, 16'h886D, 16'h9C6F};
	localparam logic [15:0] ACC_LIMITED = 16'hFE03;  // codes flagged with a speed restriction
	localparam logic [13:0] RESUME_TAB [8] = '{14'h19DC, 14'h1B9F, 14'h1D60, 14'h1F21, 14'h20DA,
		14'h229E, 14'h245E, 14'h2620};
	localparam logic [13:0] STOP_BASE_MV = 14'h170C;  // 5900 mV
	localparam logic [13:0] STOP_STEP_MV = 14'h0190;  // 400 mV
	// ****************************************************
	// Declarations
	// ****************************************************
	mpo_params_t prm;
	mpo_state_t  st;
	logic [3:0]  cnt;
	logic [3:0]  rd_addr;
	logic [7:0]  otp_result;
	logic        safe_reserved;
	logic [3:0]  amp_code;
	logic        amp_zero;
	logic        bus_wr_ok;
	assign bus_wr_ok     = reg_wr && loaded;
	assign safe_reserved = (prm.safe_target_position[10:2] == SAFE_RESERVED);  // RULE8
	// ****************************************************
	// Loader and read sequencer
	// ****************************************************
	// Walk bytes zero to nine once after reset, then serve read requests
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			st      <= ST_LOAD_REQ;
			cnt     <= 4'h0;
			loaded  <= 1'b0;
			rd_addr <= 4'h0;
		end else unique case (st)
			ST_LOAD_REQ:  st <= ST_LOAD_WAIT;
			ST_LOAD_WAIT: begin
				if (cnt == OTP_LAST) begin
					st     <= ST_RUN;
					loaded <= 1'b1;  // RULE20
				end else begin
					cnt <= cnt + 4'h1;
					st  <= ST_LOAD_REQ;
				end
			end
			ST_RUN: begin
				if (reg_wr && reg_addr == REG_OTP_ADDR) begin
					st <= ST_RD_REQ;
					if (prm.alt_safe_bank_select && reg_wdata[3:0] == OTP_POS_HI)
						rd_addr <= OTP_ALT_HI;  // RULE15
					else if (prm.alt_safe_bank_select && reg_wdata[3:0] == OTP_POS_LO)
						rd_addr <= OTP_ALT_LO;  // RULE15
					else
						rd_addr <= reg_wdata[3:0];
				end
			end
			ST_RD_REQ:    st <= ST_RD_WAIT;
			ST_RD_WAIT:   st <= ST_RUN;
			default:      st <= ST_RUN;
		endcase
	end
	// Memory strobe and address
	always_comb begin
		otp_rd   = (st == ST_LOAD_REQ) || (st == ST_RD_REQ);
		otp_addr = (st == ST_LOAD_REQ) ? cnt : rd_addr;
	end
	// Read result
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			otp_result <= 8'h00;
		else if (st == ST_RD_WAIT)
			otp_result <= otp_rdata;
	end
	// ****************************************************
	// RAM shadow
	// ****************************************************
	// Filled from memory once, then overwritten only by bus writes
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			prm <= '0;
		end else if (st == ST_LOAD_WAIT) begin
			unique case (cnt)
				OTP_BANK_BYTE: prm.alt_safe_bank_select <= otp_rdata[BANK_BIT];
				OTP_ADDR_BYTE: begin
					prm.stall_bemf_threshold <= otp_rdata[7:4];
					prm.node_addr_low_bits   <= otp_rdata[3:0];
				end
				OTP_CURR_BYTE: begin
					prm.run_code  <= otp_rdata[7:4];
					prm.hold_code <= otp_rdata[3:0];
				end
				OTP_POS_HI: begin
					prm.dir_ccw   <= otp_rdata[POS_DIR_BIT];
					prm.ramp_code <= otp_rdata[3:0];
					if (!prm.alt_safe_bank_select)
						prm.safe_target_position[10:8] <= otp_rdata[7:5];  // RULE14
				end
				OTP_POS_LO, OTP_ALT_LO: begin
					if (prm.alt_safe_bank_select == (cnt == OTP_ALT_LO)) begin  // RULE14
						prm.safe_target_position[7:0] <= {otp_rdata[7:2], 2'b00};  // RULE9
						prm.failsafe    <= otp_rdata[LO_FS_BIT];
						prm.sleep_allow <= otp_rdata[LO_SLEEP_BIT];
					end
				end
				OTP_MODE_BYTE: begin
					prm.undervoltage_level_select <= otp_rdata[6:4];
					prm.microstep_resolution      <= otp_rdata[3:2];
				end
				OTP_ALT_HI: begin
					if (prm.alt_safe_bank_select)
						prm.safe_target_position[10:8] <= otp_rdata[7:5];  // RULE14
				end
				default: ;
			endcase
		end else if (bus_wr_ok) begin
			unique case (reg_addr)
				REG_MOTOR_A: {prm.run_code, prm.hold_code} <= reg_wdata;  // RULE1
				REG_MOTOR_B: begin
					prm.ramp_code            <= reg_wdata[3:0];  // RULE1
					prm.dir_ccw              <= reg_wdata[4];
					prm.microstep_resolution <= reg_wdata[6:5];
				end
				REG_STALL_UV: begin
					prm.stall_bemf_threshold      <= reg_wdata[3:0];  // RULE1
					prm.undervoltage_level_select <= reg_wdata[6:4];
				end
				REG_SAFE_HI: prm.safe_target_position[10:8] <= reg_wdata[2:0];  // RULE1
				REG_SAFE_LO: prm.safe_target_position[7:0]  <= reg_wdata;
				default: ;
			endcase
		end
	end
	// ****************************************************
	// Register read port
	// ****************************************************
	// Data stand in the cycle after the read strobe only
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			reg_rdata <= 8'h00;
		else if (!reg_rd)
			reg_rdata <= 8'h00;
		else unique case (reg_addr)
			REG_MOTOR_A:  reg_rdata <= {prm.run_code, prm.hold_code};
			REG_MOTOR_B:  reg_rdata <= {1'b0, prm.microstep_resolution, prm.dir_ccw, prm.ramp_code};
			REG_STALL_UV: reg_rdata <= {1'b0, prm.undervoltage_level_select, prm.stall_bemf_threshold};
			REG_SAFE_HI:  reg_rdata <= {5'h00, prm.safe_target_position[10:8]};
			REG_SAFE_LO:  reg_rdata <= prm.safe_target_position[7:0];
			REG_CFG:      reg_rdata <= {5'h00, prm.alt_safe_bank_select, prm.failsafe, prm.sleep_allow};
			REG_NODE:     reg_rdata <= node_address;
			REG_STATUS:   reg_rdata <= {6'h00, (st != ST_RUN), loaded};
			REG_OTP_DATA: reg_rdata <= otp_result;
			default:      reg_rdata <= 8'h00;
		endcase
	end
	// ****************************************************
	// Parameter decode
	// ****************************************************
	// Registered decode of the shadow fields
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			node_address          <= 8'h00;
			stall_detect_en       <= 1'b0;
			low_batt_stop_level   <= 14'h0000;
			low_batt_resume_level <= 14'h0000;
			accel_rate            <= 16'h0000;
			accel_speed_limited   <= 1'b0;
			microstep_div         <= 5'h00;
			dir_ccw               <= 1'b0;
		end else begin
			node_address          <= {NODE_TOP_BIT, hardwired_addr_pins, prm.node_addr_low_bits};  // RULE2
			stall_detect_en       <= (prm.stall_bemf_threshold != 4'h0);  // RULE3
			low_batt_stop_level   <= STOP_BASE_MV + 14'(STOP_STEP_MV * prm.undervoltage_level_select);  // RULE4
			low_batt_resume_level <= RESUME_TAB[prm.undervoltage_level_select];  // RULE4
			accel_rate            <= ACC_TAB[prm.ramp_code];  // RULE16
			accel_speed_limited   <= ACC_LIMITED[prm.ramp_code];  // RULE16
			microstep_div         <= 5'h02 << prm.microstep_resolution;  // RULE13
			dir_ccw               <= prm.dir_ccw;  // RULE6
		end
	end
	// ****************************************************
	// Safe position and sleep actions
	// ****************************************************
	// One-cycle action pulses from link events
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			safe_move_start <= 1'b0;
			hold_in_place   <= 1'b0;
			sleep_enter     <= 1'b0;
			stop_enter      <= 1'b0;
		end else begin
			safe_move_start <= loaded && (goto_safe_position_cmd ||
				((link_lost || err_overflow) && !safe_reserved));  // RULE7 RULE8
			hold_in_place   <= loaded && !goto_safe_position_cmd &&
				(link_lost || err_overflow) && safe_reserved;  // RULE8
			sleep_enter     <= loaded && (((link_timeout || go_sleep_cmd) && prm.sleep_allow) ||
				(link_timeout && standby_or_shutdown));  // RULE17 RULE18 RULE19
			stop_enter      <= loaded && !prm.sleep_allow && (go_sleep_cmd ||
				(link_timeout && !standby_or_shutdown));  // RULE18 RULE19
		end
	end
	// Target from the eleven stored bits, low five bits zero
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			safe_target <= 16'h0000;
		else
			safe_target <= {prm.safe_target_position, 5'h00};  // RULE9
	end
	// ****************************************************
	// Coil current
	// ****************************************************
	mpo_hold_seq u_hold (
		.clk_sys       (clk_sys),
		.rstn          (rstn),
		.moving        (moving),
		.run_code      (prm.run_code),
		.hold_code     (prm.hold_code),
		.coil_code     (amp_code),
		.coil_zero     (amp_zero),
		.pwm_enable    (pwm_enable),
		.bottom_ground (bottom_ground)
	);
	mpo_cur_table u_amp (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.code    (amp_code),
		.boost   (boost),
		.zero    (amp_zero),
		.amp_ma  (coil_amp_ma)
	);
	// ****************************************************
	// Checks
	// ****************************************************
	sequence s_lost_event;
		loaded && (link_lost || err_overflow) && !goto_safe_position_cmd;
	endsequence
	sequence s_sleep_req;
		loaded && go_sleep_cmd && !link_timeout;
	endsequence
	AST_NO_BUS_ADDR: assert property (@(posedge clk_sys) disable iff (!rstn)  // RULE1
		st == ST_RUN |=> $stable(prm.node_addr_low_bits))
		else $error("address bits changed after load");
	AST_NODE_ADDR: assert property (@(posedge clk_sys) disable iff (!rstn)  // RULE2
		loaded |=> node_address[6:0] == {$past(hardwired_addr_pins), $past(prm.node_addr_low_bits)})
		else $error("node address not formed from pins and programmed bits");
	AST_STALL_OFF: assert property (@(posedge clk_sys) disable iff (!rstn)  // RULE3
		prm.stall_bemf_threshold == 4'h0 |=> !stall_detect_en)
		else $error("stall detection on with zero code");
	AST_SAFE_MOVE: assert property (@(posedge clk_sys) disable iff (!rstn)  // RULE7
		s_lost_event ##0 !safe_reserved |=> safe_move_start && !hold_in_place)
		else $error("no safe move after link loss");
	AST_SAFE_HOLD: assert property (@(posedge clk_sys) disable iff (!rstn)  // RULE8
		s_lost_event ##0 safe_reserved |=> hold_in_place && !safe_move_start)
		else $error("reserved pattern did not hold position");
	AST_EXPLICIT_SAFE: assert property (@(posedge clk_sys) disable iff (!rstn)  // RULE8
		loaded && goto_safe_position_cmd |=> safe_move_start)
		else $error("explicit safe command ignored");
	AST_SAFE_LOW: assert property (@(posedge clk_sys) disable iff (!rstn)  // RULE9
		loaded |-> safe_target[4:0] == 5'h00 && prm.safe_target_position[1:0] == $past(prm.safe_target_position[1:0]) ||
		$past(bus_wr_ok))
		else $error("safe low bits not zero");
	AST_SLEEP_CMD: assert property (@(posedge clk_sys) disable iff (!rstn)  // RULE19
		s_sleep_req |=> (sleep_enter == $past(prm.sleep_allow)) && (stop_enter == !$past(prm.sleep_allow)))
		else $error("sleep command outcome wrong");
	AST_TIMEOUT_SLEEP: assert property (@(posedge clk_sys) disable iff (!rstn)  // RULE17
		loaded && link_timeout && prm.sleep_allow |=> sleep_enter && !stop_enter)
		else $error("timeout with sleep allowed did not sleep");
	AST_LOAD_ONCE: assert property (@(posedge clk_sys) disable iff (!rstn)  // RULE20
		loaded |=> loaded && st != ST_LOAD_REQ)
		else $error("loader restarted");
endmodule : mpo_loader
`default_nettype wire

// [tb/mpo_otp_model.sv]
// One-time memory model answering the loader's byte reads
`timescale 1ns/1ps
`default_nettype none
module mpo_otp_model (
	// Clock
	input	wire logic			clk_sys,
	// Read port
	input	wire logic [3:0]	otp_addr,
	input	wire logic			otp_rd,
	output	logic [7:0]			otp_rdata
);
	// Bank bit set, alternate safe bytes differ from primary
	logic [7:0] mem [0:15] = '{8'h00, 8'h80, 8'h35, 8'hA7, 8'h00, 8'h5B, 8'h00, 8'h48, 8'hE0, 8'h45,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	// Data stands one cycle after the strobe, scrambled otherwise
	always_ff @(posedge clk_sys) begin
		otp_rdata <= otp_rd ? mem[otp_addr] : ~otp_rdata;
	end
endmodule : mpo_otp_model
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench of the motion parameter loader
`timescale 1ns/1ps
`default_nettype none
module tb_top import mpo_pkg::*;;
	// ****************************************************
	// Signals, design and memory
	// ****************************************************
	logic			clk_sys, rstn, reg_wr, reg_rd, otp_rd, moving, boost, loaded, standby;
	logic [2:0]		hw_pins;
	logic [3:0]		reg_addr, otp_addr;
	logic [7:0]		reg_wdata, reg_rdata, otp_rdata, node_address;
	logic [4:0]		ev;
	logic			stall_detect_en, accel_speed_limited, dir_ccw, pwm_enable, bottom_ground;
	logic [13:0]	low_batt_stop_level, low_batt_resume_level;
	logic [15:0]	accel_rate, safe_target;
	logic [4:0]		microstep_div;
	logic [10:0]	coil_amp_ma;
	logic			safe_move_start, hold_in_place, sleep_enter, stop_enter;
	int				miscompares, check_count, cycles;
	mpo_loader uut (.clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .otp_addr,
		.otp_rd, .otp_rdata, .hardwired_addr_pins(hw_pins), .link_lost(ev[0]), .err_overflow(ev[1]),
		.goto_safe_position_cmd(ev[2]), .link_timeout(ev[3]), .go_sleep_cmd(ev[4]),
		.standby_or_shutdown(standby), .moving, .boost, .node_address, .stall_detect_en,
		.low_batt_stop_level, .low_batt_resume_level, .accel_rate, .accel_speed_limited, .microstep_div,
		.dir_ccw, .coil_amp_ma, .pwm_enable, .bottom_ground, .safe_move_start, .safe_target,
		.hold_in_place, .sleep_enter, .stop_enter, .loaded);
	mpo_otp_model mem_i (.clk_sys, .otp_addr, .otp_rd, .otp_rdata);
	// Clock and cycle ceiling
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 2000) begin
			miscompares++;
			test_done();
		end
	end
	// ****************************************************
	// Shared tasks
	// ****************************************************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
		@(posedge clk_sys) reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk_sys) {reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge clk_sys) reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask : rd
	task automatic pulse(input int i);
		@(posedge clk_sys) ev[i] <= 1'b1;
		@(posedge clk_sys) ev[i] <= 1'b0;
		#1;
	endtask : pulse
	task automatic test_done();
		if (miscompares == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : test_done
	// ****************************************************
	// Scenarios
	// ****************************************************
	task automatic t_load();
		chk(node_address, 16'h0055);
		chk(accel_rate, 16'h5F7F);
		chk(accel_speed_limited, 16'h0001);
		chk(microstep_div, 16'h0008);
		chk(dir_ccw, 16'h0001);
		chk(stall_detect_en, 16'h0001);
		chk(low_batt_stop_level, 16'h1D4C);
		chk(low_batt_resume_level, 16'h20DA);
		chk(safe_target, 16'hE880);
		chk(coil_amp_ma, 16'h00C8);
	endtask : t_load
	task automatic t_writes();
		wr(REG_OTP_ADDR, 8'h05);
		repeat (4) @(posedge clk_sys);
		rd(REG_OTP_DATA, 8'hE0);
		wr(REG_NODE, 8'h00);
		wr(REG_STALL_UV, 8'h00);
		repeat (2) @(posedge clk_sys);
		#1 chk(node_address, 16'h0055);
		chk(stall_detect_en, 16'h0000);
		chk(low_batt_stop_level, 16'h170C);
		chk(low_batt_resume_level, 16'h19DC);
		rd(4'hF, 8'h00);
	endtask : t_writes
	task automatic t_hold();
		@(posedge clk_sys) moving <= 1'b1;
		repeat (4) @(posedge clk_sys);
		#1 chk(coil_amp_ma, 16'h0150);
		wr(REG_MOTOR_A, 8'hFF);
		rd(REG_MOTOR_A, 8'hFF);
		chk(coil_amp_ma, 16'h0320);
		@(posedge clk_sys) moving <= 1'b0;
		repeat (10) @(posedge clk_sys);
		#1 chk(coil_amp_ma, 16'h003B);
		chk(pwm_enable, 16'h0001);
		repeat (40) @(posedge clk_sys);
		#1 chk({pwm_enable, bottom_ground, coil_amp_ma}, 16'h0800);
		@(posedge clk_sys) {moving, boost} <= 2'b11;
		repeat (3) @(posedge clk_sys);
		#1 chk(coil_amp_ma, 16'h044C);
		@(posedge clk_sys) moving <= 1'b0;
		repeat (4) @(posedge clk_sys);
		#1 chk(coil_amp_ma, 16'h0051);
		@(posedge clk_sys) boost <= 1'b0;
	endtask : t_hold
	task automatic t_events();
		pulse(1);
		chk(safe_move_start, 16'h0001);
		wr(REG_SAFE_HI, 8'h04);
		wr(REG_SAFE_LO, 8'h00);
		repeat (2) @(posedge clk_sys);
		#1 chk(safe_target, 16'h8000);
		pulse(0);
		chk({safe_move_start, hold_in_place}, 16'h0001);
		pulse(2);
		chk(safe_move_start, 16'h0001);
		pulse(4);
		chk({sleep_enter, stop_enter}, 16'h0002);
		pulse(3);
		chk(sleep_enter, 16'h0001);
	endtask : t_events
	// Mid-run reset with primary bank, sleep not allowed, other pins
	task automatic t_reload();
		@(posedge clk_sys) {rstn, hw_pins} <= {1'b0, 3'h2};
		mem_i.mem[1] = 8'h00;
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (25) @(posedge clk_sys);
		#1 chk(loaded, 16'h0001);
		chk(node_address, 16'h0025);
		chk(safe_target, 16'h4000);
		wr(REG_OTP_ADDR, 8'h05);
		repeat (4) @(posedge clk_sys);
		rd(REG_OTP_DATA, 8'h5B);
		pulse(3);
		chk({sleep_enter, stop_enter}, 16'h0001);
		pulse(4);
		chk({sleep_enter, stop_enter}, 16'h0001);
		@(posedge clk_sys) standby <= 1'b1;
		pulse(3);
		chk({sleep_enter, stop_enter}, 16'h0002);
	endtask : t_reload
	// Main sequence
	initial begin
		{rstn, reg_wr, reg_rd, moving, boost, standby, ev, reg_addr, reg_wdata} = '0;
		hw_pins = 3'h5;
		repeat (12) @(posedge clk_sys);
		rstn <= 1'b1;
		for (int i = 0; i < 60 && loaded !== 1'b1; i++) @(posedge clk_sys);
		repeat (2) @(posedge clk_sys);
		#1 chk(loaded, 16'h0001);
		t_load();
		t_writes();
		t_hold();
		t_events();
		t_reload();
		test_done();
	end
endmodule : tb_top
`default_nettype wire
